// >>> hw/dma_chan_cfg_defines.vh
// Register offsets, field positions, reset values and codes of the DMA channel setup logic
`ifndef DMA_CHAN_CFG_DEFINES_VH
`define DMA_CHAN_CFG_DEFINES_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define IRQ_STATUS_OFS 12'h000
`define IRQ_MASK_OFS 12'h004
`define ENABLED_SUMMARY_OFS 12'h01C
// Channel setup words sit at 0x110 + 0x20 * channel
`define CFG_PAGE 4'h1
`define CFG_SLOT 5'h10

// ----------------------------------------------------------------------------
// Channel setup word fields
// ----------------------------------------------------------------------------
`define HALT_BIT 18
`define ACTIVE_BIT 17
`define LOCK_BIT 16
`define TC_MASK_BIT 15
`define ERR_MASK_BIT 14
`define FLOW_HI 13
`define FLOW_LO 11
`define DST_SEL_HI 9
`define DST_SEL_LO 6
`define SRC_SEL_HI 4
`define SRC_SEL_LO 1
`define ENABLE_BIT 0
`define CFG_WRITE_MASK 32'h0005FBDE

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CFG_RESET 32'h00000000
`define IRQ_MASK_RESET 32'h00000000
`define IRQ_STATUS_RESET 32'h00000000

// ----------------------------------------------------------------------------
// Flow and transfer type codes
// ----------------------------------------------------------------------------
`define FLOW_M2M 3'h0
`define FLOW_M2P 3'h1
`define FLOW_P2M 3'h2
`define FLOW_P2P 3'h3
`define FLOW_P2P_DST 3'h4
`define FLOW_M2P_PER 3'h5
`define FLOW_P2M_PER 3'h6
`define FLOW_P2P_SRC 3'h7

`endif

// >>> hw/dma_channel_config_control.v
// Per-channel setup word, enable and halt control of a multi-channel DMA controller
//
// What this block does
// - Error interrupt passes only when bit 14 set
// - Bits 13:11 pick direction and flow controller
// - Flow codes 000 to 111 decoded as listed
// - Bits 9:6 pick destination request line
// - Destination select ignored when writing memory
// - Bits 4:1 pick source request line
// - Source select ignored when reading memory
// - Bits 10 and 5 reserved, written zero
// - Bit 0 reads live channel enable state
// - Summary register mirrors every channel enable bit
// - Writing enable one starts the channel
// - Clearing enable waits for current AHB transfer
// - Software disable discards remaining FIFO data
// - Last item or error disables channel itself
// - Halt blocks source requests, FIFO keeps draining
// - Bit 17 reads one while FIFO holds data
//
// Design decisions made here: the register addresses and strobed register access.
`default_nettype none
`include "dma_chan_cfg_defines.vh"

module dma_channel_config_control #(
    parameter N_CHAN = 8,
    parameter N_REQ = 16
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Register port
    input wire [11:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Interrupt
    output wire irq,
    // Channel engine status
    input wire [N_CHAN-1:0] ahb_busy,
    input wire [N_CHAN-1:0] fifo_has_data,
    input wire [N_CHAN-1:0] lli_last_done,
    input wire [N_CHAN-1:0] chan_error,
    // Channel engine control
    output wire [N_CHAN-1:0] chan_run,
    output wire [N_CHAN-1:0] fifo_flush,
    output wire [3*N_CHAN-1:0] flow_code,
    output wire [N_CHAN-1:0] src_is_periph,
    output wire [N_CHAN-1:0] dst_is_periph,
    output wire [N_CHAN-1:0] flow_by_src,
    output wire [N_CHAN-1:0] flow_by_dst,
    output wire [N_CHAN-1:0] lock_en,
    // Peripheral request lines
    input wire [N_REQ-1:0] periph_req,
    output wire [N_CHAN-1:0] src_req_out,
    output wire [N_CHAN-1:0] dst_req_out
);

    // ------------------------------------------------------------------------
    // Request line synchroniser
    // ------------------------------------------------------------------------
    reg [N_REQ-1:0] req_meta_reg;
    reg [N_REQ-1:0] req_sync_reg;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            req_meta_reg <= {N_REQ{1'b0}};
            req_sync_reg <= {N_REQ{1'b0}};
        end else begin
            req_meta_reg <= periph_req;
            req_sync_reg <= req_meta_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    wire cfg_hit;
    wire [2:0] cfg_idx;
    wire [N_CHAN-1:0] cfg_wr;
    wire status_wr;
    wire mask_wr;
    wire [31:0] cfg_flat_rd [0:N_CHAN-1];
    wire [N_CHAN-1:0] enable_vec;
    wire [N_CHAN-1:0] err_ie_vec;

    assign cfg_hit = (reg_addr[11:8] == `CFG_PAGE) && (reg_addr[4:0] == `CFG_SLOT)
                     && ({29'h0, reg_addr[7:5]} < N_CHAN);
    assign cfg_idx = reg_addr[7:5];
    assign status_wr = reg_wr && (reg_addr == `IRQ_STATUS_OFS);
    assign mask_wr = reg_wr && (reg_addr == `IRQ_MASK_OFS);

    // ------------------------------------------------------------------------
    // Per-channel setup word and enable control
    // ------------------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < N_CHAN; ch = ch + 1) begin : g_ch
            reg [31:0] cfg_reg;
            reg enable_reg;
            reg stop_pending_reg;
            reg flush_reg;
            wire [2:0] flow;
            wire [3:0] src_sel;
            wire [3:0] dst_sel;
            wire sw_write;

            assign sw_write = reg_wr && cfg_hit && (cfg_idx == ch);
            assign cfg_wr[ch] = sw_write;

            // Reserved bits are never stored, so they read back as zero
            always @(posedge clk_sys) begin
                if (!rst_n) begin
                    cfg_reg <= `CFG_RESET;
                end else if (sw_write) begin
                    cfg_reg <= reg_wdata & `CFG_WRITE_MASK;
                end
            end

            // Hardware disable beats a software enable in the same cycle,
            // since a finished or failed channel must not restart by itself.
            always @(posedge clk_sys) begin
                if (!rst_n) begin
                    enable_reg <= 1'b0;
                    stop_pending_reg <= 1'b0;
                    flush_reg <= 1'b0;
                end else begin
                    flush_reg <= 1'b0;
                    if (enable_reg && (lli_last_done[ch] || chan_error[ch])) begin
                        enable_reg <= 1'b0;
                        stop_pending_reg <= 1'b0;
                    end else if (sw_write && reg_wdata[`ENABLE_BIT]) begin
                        enable_reg <= 1'b1;
                        stop_pending_reg <= 1'b0;
                    end else if (sw_write && enable_reg) begin
                        stop_pending_reg <= 1'b1;
                    end else if (stop_pending_reg && !ahb_busy[ch]) begin
                        enable_reg <= 1'b0;
                        stop_pending_reg <= 1'b0;
                        flush_reg <= 1'b1;
                    end
                end
            end

            assign flow = cfg_reg[`FLOW_HI:`FLOW_LO];
            assign src_sel = cfg_reg[`SRC_SEL_HI:`SRC_SEL_LO];
            assign dst_sel = cfg_reg[`DST_SEL_HI:`DST_SEL_LO];

            // One row per flow code, so each row can be checked on its own
            reg src_periph;
            reg dst_periph;
            reg paced_by_src;
            reg paced_by_dst;

            always @* begin
                src_periph = 1'b0;
                dst_periph = 1'b0;
                paced_by_src = 1'b0;
                paced_by_dst = 1'b0;
                case (flow)
                    `FLOW_M2M: begin
                        src_periph = 1'b0;
                        dst_periph = 1'b0;
                        paced_by_src = 1'b0;
                        paced_by_dst = 1'b0;
                    end
                    `FLOW_M2P: begin
                        src_periph = 1'b0;
                        dst_periph = 1'b1;
                        paced_by_src = 1'b0;
                        paced_by_dst = 1'b0;
                    end
                    `FLOW_P2M: begin
                        src_periph = 1'b1;
                        dst_periph = 1'b0;
                        paced_by_src = 1'b0;
                        paced_by_dst = 1'b0;
                    end
                    `FLOW_P2P: begin
                        src_periph = 1'b1;
                        dst_periph = 1'b1;
                        paced_by_src = 1'b0;
                        paced_by_dst = 1'b0;
                    end
                    `FLOW_P2P_DST: begin
                        src_periph = 1'b1;
                        dst_periph = 1'b1;
                        paced_by_src = 1'b0;
                        paced_by_dst = 1'b1;
                    end
                    `FLOW_M2P_PER: begin
                        src_periph = 1'b0;
                        dst_periph = 1'b1;
                        paced_by_src = 1'b0;
                        paced_by_dst = 1'b1;
                    end
                    `FLOW_P2M_PER: begin
                        src_periph = 1'b1;
                        dst_periph = 1'b0;
                        paced_by_src = 1'b1;
                        paced_by_dst = 1'b0;
                    end
                    `FLOW_P2P_SRC: begin
                        src_periph = 1'b1;
                        dst_periph = 1'b1;
                        paced_by_src = 1'b1;
                        paced_by_dst = 1'b0;
                    end
                    default: begin
                        src_periph = 1'b0;
                        dst_periph = 1'b0;
                        paced_by_src = 1'b0;
                        paced_by_dst = 1'b0;
                    end
                endcase
            end

            assign src_is_periph[ch] = src_periph;
            assign dst_is_periph[ch] = dst_periph;
            assign flow_by_src[ch] = paced_by_src;
            assign flow_by_dst[ch] = paced_by_dst;
            assign flow_code[3*ch +: 3] = flow;
            assign lock_en[ch] = cfg_reg[`LOCK_BIT];

            // A pending stop already blocks new beats; the engine only finishes
            // the transfer it has on the bus.
            assign chan_run[ch] = enable_reg && !stop_pending_reg;
            assign fifo_flush[ch] = flush_reg;
            assign enable_vec[ch] = enable_reg;
            assign err_ie_vec[ch] = cfg_reg[`ERR_MASK_BIT];

            // Source side obeys halt, destination side keeps draining the FIFO
            assign src_req_out[ch] = chan_run[ch] && src_is_periph[ch]
                                     && !cfg_reg[`HALT_BIT]
                                     && req_sync_reg[src_sel];
            assign dst_req_out[ch] = chan_run[ch] && dst_is_periph[ch]
                                     && req_sync_reg[dst_sel];

            assign cfg_flat_rd[ch] = {cfg_reg[31:18], fifo_has_data[ch],
                                      cfg_reg[16:1], enable_reg};
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------------
    // Status layout: error events in the low N_CHAN bits, last-item
    // completions in the next N_CHAN bits.
    reg [31:0] irq_status_reg;
    reg [31:0] irq_mask_reg;
    wire [31:0] irq_event;
    wire [31:0] irq_gate;
    wire [31:0] status_clear;

    assign irq_event = {{(32-2*N_CHAN){1'b0}}, lli_last_done & enable_vec, chan_error};
    assign status_clear = status_wr ? reg_wdata : 32'h00000000;

    // Set wins over a write-one clear landing in the same cycle
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_status_reg <= `IRQ_STATUS_RESET;
        end else begin
            irq_status_reg <= (irq_status_reg & ~status_clear) | irq_event;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_mask_reg <= `IRQ_MASK_RESET;
        end else if (mask_wr) begin
            irq_mask_reg <= reg_wdata;
        end
    end

    // Error bits additionally need the channel's own error mask bit
    assign irq_gate = irq_mask_reg & {{(32-2*N_CHAN){1'b0}}, {N_CHAN{1'b1}}, err_ie_vec};
    assign irq = |(irq_status_reg & irq_gate);

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    reg [31:0] rdata_next;

    always @* begin
        rdata_next = 32'h00000000;
        if (cfg_hit) begin
            rdata_next = cfg_flat_rd[cfg_idx];
        end else if (reg_addr == `IRQ_STATUS_OFS) begin
            rdata_next = irq_status_reg;
        end else if (reg_addr == `IRQ_MASK_OFS) begin
            rdata_next = irq_mask_reg;
        end else if (reg_addr == `ENABLED_SUMMARY_OFS) begin
            rdata_next = {{(32-N_CHAN){1'b0}}, enable_vec};
        end
    end

    // Data only stands in the cycle after the read strobe; zero otherwise
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule
`default_nettype wire

// >>> tb/dma_cfg_asserts.sv
// Port checker for the DMA channel setup block, channel 0
`default_nettype none
module dma_cfg_asserts #(parameter N_CHAN = 8) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Engine side
    input wire logic [N_CHAN-1:0] ahb_busy,
    input wire logic [N_CHAN-1:0] fifo_has_data,
    input wire logic [N_CHAN-1:0] chan_error,
    input wire logic [N_CHAN-1:0] chan_run,
    input wire logic [N_CHAN-1:0] fifo_flush,
    input wire logic [3*N_CHAN-1:0] flow_code,
    input wire logic [N_CHAN-1:0] src_is_periph,
    input wire logic [N_CHAN-1:0] dst_is_periph,
    input wire logic [N_CHAN-1:0] src_req_out,
    input wire logic [N_CHAN-1:0] dst_req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] SRC_P = 8'hDC;
    localparam logic [7:0] DST_P = 8'hBA;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // --------------------------------
    // Reads, decode and stop sequence
    // --------------------------------
    sequence s_rd0;
        $past(reg_rd) && $past(reg_addr) == 12'h110;
    endsequence
    sequence s_stop;
        reg_wr && reg_addr == 12'h110 && !reg_wdata[0] && chan_run[0];
    endsequence
    property p_resv;
        s_rd0 |-> reg_rdata[31:19] == 13'h0 && !reg_rdata[10] && !reg_rdata[5];
    endproperty
    property p_active;
        s_rd0 |-> reg_rdata[17] == $past(fifo_has_data[0]);
    endproperty
    property p_summary;
        $past(reg_rd) && $past(reg_addr) == 12'h01C
            |-> (reg_rdata[N_CHAN-1:0] & $past(chan_run)) == $past(chan_run);
    endproperty
    property p_decode;
        src_is_periph[0] == SRC_P[flow_code[2:0]] && dst_is_periph[0] == DST_P[flow_code[2:0]];
    endproperty
    property p_sreq;
        src_req_out[0] |-> chan_run[0] && src_is_periph[0];
    endproperty
    property p_dreq;
        dst_req_out[0] |-> chan_run[0] && dst_is_periph[0];
    endproperty
    property p_err;
        chan_error[0] && chan_run[0] |=> !chan_run[0];
    endproperty
    property p_stop;
        s_stop |=> !chan_run[0];
    endproperty
    // Flush only once the bus is quiet, and only for one cycle
    property p_flush;
        fifo_flush[0] |-> !$past(ahb_busy[0]) && !chan_run[0] ##1 !fifo_flush[0];
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits set");
    a_active: assert property (p_active) else $error("active bit wrong");
    a_summary: assert property (p_summary) else $error("summary wrong");
    a_decode: assert property (p_decode) else $error("flow decode wrong");
    a_sreq: assert property (p_sreq) else $error("stray source request");
    a_dreq: assert property (p_dreq) else $error("stray dest request");
    a_err: assert property (p_err) else $error("no stop on error");
    a_stop: assert property (p_stop) else $error("run after disable");
    a_flush: assert property (p_flush) else $error("bad flush");
endmodule
bind dma_channel_config_control dma_cfg_asserts #(.N_CHAN(N_CHAN)) u_dma_cfg_asserts (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ahb_busy,
    .fifo_has_data, .chan_error, .chan_run, .fifo_flush, .flow_code, .src_is_periph,
    .dst_is_periph, .src_req_out, .dst_req_out);
`default_nettype wire

// >>> tb/engine_model.sv
// Behavioural channel engine and request pins beside the setup block
`default_nettype none
module engine_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Bench commands
    input wire logic slow,
    input wire logic do_err,
    input wire logic do_done,
    input wire logic [15:0] req_pins,
    // Setup block side
    input wire logic [7:0] src_req_out,
    output logic [7:0] ahb_busy,
    output logic [7:0] fifo_has_data,
    output logic [7:0] lli_last_done,
    output logic [7:0] chan_error,
    output logic [15:0] periph_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt;
    // Each accepted request refills the FIFO; a slow bus drains it late
    always @(posedge clk_sys) begin
        if (!rst_n)
            cnt <= 3'h0;
        else if (src_req_out[0])
            cnt <= slow ? 3'h6 : 3'h1;
        else if (cnt != 3'h0)
            cnt <= cnt - 3'h1;
        lli_last_done <= {7'h00, do_done && rst_n};
        chan_error <= {7'h00, do_err && rst_n};
    end
    assign ahb_busy = {7'h00, cnt != 3'h0};
    assign fifo_has_data = ahb_busy;
    assign periph_req = req_pins;
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the DMA channel setup block
`default_nettype none
`include "dma_chan_cfg_defines.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] SRC_P = 8'hDC;
    localparam logic [7:0] DST_P = 8'hBA;
    logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq;
    logic slow = 1'b0, do_err = 1'b0, do_done = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic [15:0] req_pins = 16'h0, periph_req;
    logic [7:0] ahb_busy, fifo_has_data, lli_last_done, chan_error, chan_run, fifo_flush;
    logic [7:0] src_is_periph, dst_is_periph, flow_by_src, flow_by_dst, src_req_out, dst_req_out;
    logic [23:0] flow_code;
    int mismatches = 0, n_tests = 0;
    always #5 clk_sys = ~clk_sys;
    dma_channel_config_control u_dma_channel_config_control (.clk_sys, .rst_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .ahb_busy, .fifo_has_data,
        .lli_last_done, .chan_error, .chan_run, .fifo_flush, .flow_code, .src_is_periph,
        .dst_is_periph, .flow_by_src, .flow_by_dst, .lock_en(), .periph_req, .src_req_out,
        .dst_req_out);
    engine_model u_engine_model (.clk_sys, .rst_n, .slow, .do_err, .do_done, .req_pins,
        .src_req_out, .ahb_busy, .fifo_has_data, .lli_last_done, .chan_error, .periph_req);
    // --------------------------------
    // Bus and check tasks
    // --------------------------------
    task automatic end_sim;
        $display("Checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", n, e, g);
            mismatches++;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk_sys);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic pins(input logic [15:0] p);
        @(posedge clk_sys);
        req_pins <= p;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic pulse(input logic e);
        @(posedge clk_sys);
        {do_err, do_done} <= {e, !e};
        @(posedge clk_sys);
        {do_err, do_done} <= 2'b00;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic wait_flush;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            #1 if (fifo_flush[0] === 1'b1) return;
        end
        $display("[ERR] fifo_flush exp 1 got 0");
        mismatches++;
        end_sim;
    endtask
    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic s_reset;
        rd(12'h110); chk("setup", `CFG_RESET, d);
        rd(`IRQ_MASK_OFS); chk("mask", `IRQ_MASK_RESET, d);
        rd(12'hFFC); chk("unmapped", 32'h0, d);
        chk("irq", 32'h0, irq);
    endtask
    task automatic s_flow;
        for (int c = 0; c < 8; c++) begin
            wr(12'h110, {18'h0, c[2:0], 11'h0});
            chk("flow", c, flow_code[2:0]);
            chk("src_p", SRC_P[c], src_is_periph[0]);
            chk("dst_p", DST_P[c], dst_is_periph[0]);
            chk("by_src", c > 5, flow_by_src[0]);
            chk("by_dst", c == 4 || c == 5, flow_by_dst[0]);
        end
    endtask
    // Source line 5, destination line 9; a halted channel drains, then stops cleanly
    task automatic s_req;
        wr(12'h110, 32'h00001A4B);
        pins(16'h0020); chk("sreq", 32'h1, src_req_out[0]);
        chk("dreq_off", 32'h0, dst_req_out[0]);
        rd(12'h110); chk("live", 32'h00021A4B, d);
        rd(`ENABLED_SUMMARY_OFS); chk("summary", 32'h1, d);
        pins(16'h0200); chk("dreq", 32'h1, dst_req_out[0]);
        chk("sreq_off", 32'h0, src_req_out[0]);
        wr(12'h110, 32'h00041A4B);
        pins(16'h0220); chk("halt", 32'h0, src_req_out[0]);
        rd(12'h110);
        for (int i = 0; i < 20 && d[17]; i++) rd(12'h110);
        chk("drained", 32'h0, d[17]);
        wr(12'h110, 32'h0);
        wait_flush;
        rd(12'h110); chk("off", 32'h0, d[0]);
    endtask
    // A slow bus keeps the stop pending until its transfer ends
    task automatic s_busy;
        @(posedge clk_sys);
        slow <= 1'b1;
        wr(12'h110, 32'h00001A4B);
        pins(16'h0020);
        wr(12'h110, 32'h0); chk("run_off", 32'h0, chan_run[0]);
        rd(12'h110); chk("pending", 32'h1, d[0]);
        wait_flush;
        rd(12'h110); chk("stopped", 32'h0, d[0]);
        @(posedge clk_sys);
        slow <= 1'b0;
    endtask
    task automatic s_err;
        wr(`IRQ_MASK_OFS, 32'h1);
        wr(12'h110, 32'h1);
        pulse(1'b1); chk("err_stop", 32'h0, chan_run[0]);
        chk("irq_masked", 32'h0, irq);
        rd(`IRQ_STATUS_OFS); chk("status", 32'h1, d);
        wr(12'h110, 32'h00004000); chk("irq_on", 32'h1, irq);
        wr(`IRQ_STATUS_OFS, 32'h1); chk("irq_clr", 32'h0, irq);
        wr(12'h110, 32'h1);
        pulse(1'b0); rd(12'h110); chk("last_item", 32'h0, d[0]);
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        s_reset;
        s_flow;
        s_req;
        s_busy;
        s_err;
        end_sim;
    end
endmodule
`default_nettype wire
